// File: common/htd_pkg.sv
// Shared constants and carrier types of the transfer descriptor engine
package htd_pkg;

  // ********************************************************
  // Register map (byte addresses on the APB)
  // ********************************************************
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_FRAME  = 8'h0c;
  localparam logic [7:0] OFF_PEND   = 8'h10;
  localparam logic [7:0] OFF_AEND   = 8'h14;
  localparam logic [7:0] OFF_ENGINE = 8'h18;
  localparam logic [7:0] OFF_DESC   = 8'h80;
  localparam int unsigned DESC_SHIFT = 3;
  localparam int unsigned WORD_SEL_BIT = 2;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_KIND_LSB = 1;
  localparam int unsigned ENG_BUSY_BIT  = 8;
  localparam int unsigned ENG_PING_BIT  = 9;

  localparam int unsigned ST_DESC_DONE  = 0;
  localparam int unsigned ST_ERR        = 1;
  localparam int unsigned ST_LIST_DONE  = 2;
  localparam int unsigned ST_W          = 3;

  localparam int unsigned LEN_W   = 10;
  localparam int unsigned FRAME_W = 11;

  // ********************************************************
  // Codes
  // ********************************************************
  localparam logic [3:0] CC_OK        = 4'h0;
  localparam logic [3:0] CC_OVERRUN   = 4'hc;
  localparam logic [3:0] CC_UNDERRUN  = 4'hd;
  localparam logic [1:0] TK_SETUP     = 2'h0;
  localparam logic [1:0] TK_OUT       = 2'h1;
  localparam logic [1:0] TK_IN        = 2'h2;
  localparam logic [1:0] TK_RSV       = 2'h3;
  localparam logic [1:0] LK_APER      = 2'h0;
  localparam logic [1:0] LK_INTR      = 2'h1;
  localparam logic [1:0] LK_ISO       = 2'h2;

  // ********************************************************
  // Descriptor, byte 7 at the top, byte 0 at the bottom
  // ********************************************************
  typedef struct packed {
    logic [7:0] sched_byte;
    logic       rsv6;
    logic [6:0] peripheral_addr;
    logic       paired;
    logic       pingpong;
    logic [1:0] token_kind;
    logic       rsv5;
    logic       low_speed;
    logic [1:0] len_hi;
    logic [7:0] len_lo;
    logic [3:0] endpoint_index;
    logic       last;
    logic       rsv3;
    logic [1:0] mps_hi;
    logic [7:0] mps_lo;
    logic [3:0] outcome_code;
    logic       toggle;
    logic       active;
    logic [1:0] moved_hi;
    logic [7:0] moved_lo;
  } htd_desc_s;

  typedef struct packed {
    logic [1:0]       token_kind;
    logic [6:0]       peripheral_addr;
    logic [3:0]       endpoint_index;
    logic             low_speed;
    logic             data1;
    logic [LEN_W-1:0] byte_len;
  } htd_token_s;

  typedef struct packed {
    logic       ok;
    logic [3:0] outcome_code;
  } htd_result_s;

endpackage

// File: logic/htd_byte_pacer.sv
// Per-packet byte counter and memory pacing fault detector
`timescale 1ns/100ps
module htd_byte_pacer #(
  parameter int unsigned CNT_W = htd_pkg::LEN_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic             dir_in,
  input  wire logic             in_byte_stb,
  input  wire logic             mem_wr_rdy,
  input  wire logic             out_byte_req,
  input  wire logic             mem_rd_rdy,
  output logic      [CNT_W-1:0] byte_count,
  output logic                  overrun,
  output logic                  underrun
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             ovr;
    logic             und;
  } htd_pacer_s;

  htd_pacer_s q;
  htd_pacer_s d;

  always_comb begin
    d = q;
    if (clear) begin
      d = '0;
    end else if (dir_in && in_byte_stb) begin
      // A byte that memory cannot take is lost, not retried
      if (!mem_wr_rdy) begin
        d.ovr = 1'b1;
      end else begin
        d.cnt = CNT_W'(q.cnt + 1'b1);
      end
    end else if (!dir_in && out_byte_req) begin
      if (!mem_rd_rdy) begin
        d.und = 1'b1;
      end else begin
        d.cnt = CNT_W'(q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign byte_count = q.cnt;
  assign overrun    = q.ovr;
  assign underrun   = q.und;

endmodule

// File: logic/htd_engine.sv
// Transfer descriptor engine: APB registers, list scan, token issue and write-back
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

module htd_engine #(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [htd_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic                                   irq,
  input  wire logic                              sof,
  output logic                                   tok_valid,
  output htd_pkg::htd_token_s                    tok,
  input  wire logic                              res_valid,
  input  wire htd_pkg::htd_result_s              res,
  input  wire logic                              in_byte_stb,
  input  wire logic                              mem_wr_rdy,
  input  wire logic                              out_byte_req,
  input  wire logic                              mem_rd_rdy
);

  localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [7:0]  DESC_SPAN = 8'(DEPTH * 8);

  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_WAIT, S_NEXT} htd_fsm_e;

  typedef struct packed {
    htd_pkg::htd_desc_s [DEPTH-1:0] desc;
    logic                           ctrl_en;
    logic [1:0]                     kind;
    logic [htd_pkg::ST_W-1:0]       status;
    logic [htd_pkg::ST_W-1:0]       mask;
    logic [htd_pkg::FRAME_W-1:0]    frame;
    logic [IDX_W-1:0]               pend;
    logic [IDX_W-1:0]               aend;
    logic [IDX_W-1:0]               idx;
    htd_fsm_e                       fsm;
    htd_pkg::htd_token_s            tok;
    logic                           ping_sent;
    logic [31:0]                    rdata;
    logic                           slverr;
  } htd_state_s;

  htd_state_s q;
  htd_state_s n;

  // ********************************************************
  // Field helpers
  // ********************************************************
  function automatic logic [9:0] f_moved(input htd_pkg::htd_desc_s dd);
    f_moved = {dd.moved_hi, dd.moved_lo};
  endfunction

  function automatic logic [9:0] f_total(input htd_pkg::htd_desc_s dd);
    f_total = {dd.len_hi, dd.len_lo};
  endfunction

  function automatic logic [9:0] f_mps(input htd_pkg::htd_desc_s dd);
    f_mps = {dd.mps_hi, dd.mps_lo};
  endfunction

  function automatic logic f_desc_hit(input logic [7:0] a);
    f_desc_hit = (a >= htd_pkg::OFF_DESC) && (8'(a - htd_pkg::OFF_DESC) < DESC_SPAN) &&
                 (a[1:0] == 2'h0);
  endfunction

  // Poll when the frame matches first_frame modulo the interval
  function automatic logic f_poll_due(input logic [7:0] sb, input logic [7:0] fr);
    logic [7:0] pmask;
    pmask = 8'(8'h01 << sb[7:5]) - 8'h01;
    f_poll_due = ((fr ^ {3'h0, sb[4:0]}) & pmask) == 8'h00;
  endfunction

  htd_pkg::htd_desc_s cur;
  logic [IDX_W-1:0]   di;
  logic               setup;
  logic               access;
  logic               sched_ok;
  logic               pair_ok;
  logic               eligible;
  logic               list_end;
  logic               start_pkt;
  logic [9:0]         remain;
  logic [9:0]         moved_new;
  logic [htd_pkg::ST_W-1:0] ev;
  logic [31:0]        rd_data;
  logic               hit;
  logic [9:0]         pc_count;
  logic               pc_over;
  logic               pc_under;

  assign cur    = q.desc[q.idx];
  assign di     = IDX_W'(8'(paddr - htd_pkg::OFF_DESC) >> htd_pkg::DESC_SHIFT);
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // ********************************************************
  // Scheduling decisions for the descriptor under the scan
  // ********************************************************
  always_comb begin
    case (q.kind)
      htd_pkg::LK_INTR: sched_ok = f_poll_due(cur.sched_byte, q.frame[7:0]);
      htd_pkg::LK_ISO:  sched_ok = cur.sched_byte == q.frame[7:0];
      default:          sched_ok = 1'b1;
    endcase
  end

  // A pong half waits for the ping half of the pair to go out
  assign pair_ok  = !cur.paired || !cur.pingpong || q.ping_sent;
  assign eligible = cur.active && (cur.token_kind != htd_pkg::TK_RSV) &&
                    sched_ok && pair_ok;
  assign list_end = (q.idx == IDX_W'(DEPTH - 1)) ||
                    ((q.kind == htd_pkg::LK_ISO) ? cur.last :
                     (q.idx == ((q.kind == htd_pkg::LK_INTR) ? q.pend : q.aend)));
  assign remain   = (f_moved(cur) >= f_total(cur)) ? 10'h000 :
                    10'(f_total(cur) - f_moved(cur));
  assign start_pkt = (q.fsm == S_SCAN) && eligible;

  // ********************************************************
  // Register read mux
  // ********************************************************
  always_comb begin
    rd_data = '0;
    hit     = 1'b1;
    case (paddr)
      htd_pkg::OFF_CTRL: begin
        rd_data[htd_pkg::CTRL_EN_BIT]         = q.ctrl_en;
        rd_data[htd_pkg::CTRL_KIND_LSB +: 2] = q.kind;
      end
      htd_pkg::OFF_STATUS: rd_data[htd_pkg::ST_W-1:0]    = q.status;
      htd_pkg::OFF_MASK:   rd_data[htd_pkg::ST_W-1:0]    = q.mask;
      htd_pkg::OFF_FRAME:  rd_data[htd_pkg::FRAME_W-1:0] = q.frame;
      htd_pkg::OFF_PEND:   rd_data[IDX_W-1:0]            = q.pend;
      htd_pkg::OFF_AEND:   rd_data[IDX_W-1:0]            = q.aend;
      htd_pkg::OFF_ENGINE: begin
        rd_data[IDX_W-1:0]                = q.idx;
        rd_data[htd_pkg::ENG_BUSY_BIT]    = q.fsm != S_IDLE;
        rd_data[htd_pkg::ENG_PING_BIT]    = q.ping_sent;
      end
      default: begin
        if (f_desc_hit(paddr)) begin
          rd_data = paddr[htd_pkg::WORD_SEL_BIT] ? q.desc[di][63:32] : q.desc[di][31:0];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    n         = q;
    ev        = '0;
    moved_new = 10'(f_moved(cur) + pc_count);
    if (setup) begin
      // Sampled in setup so the answer is ready with zero wait states
      n.rdata  = rd_data;
      n.slverr = !hit;
    end
    if (sof) begin
      n.frame = htd_pkg::FRAME_W'(q.frame + 1'b1);
    end
    case (q.fsm)
      S_IDLE: begin
        if (sof && q.ctrl_en) begin
          n.idx = '0;
          n.fsm = S_SCAN;
        end
      end
      S_SCAN: begin
        if (eligible) begin
          n.tok.token_kind      = cur.token_kind;
          n.tok.peripheral_addr = cur.peripheral_addr;
          n.tok.endpoint_index  = cur.endpoint_index;
          n.tok.low_speed       = cur.low_speed;
          n.tok.data1           = cur.toggle;
          n.tok.byte_len        = (remain > f_mps(cur)) ? f_mps(cur) : remain;
          n.fsm                 = S_WAIT;
        end else begin
          n.fsm = S_NEXT;
        end
      end
      S_WAIT: begin
        if (res_valid) begin
          n.fsm = S_NEXT;
          n.desc[q.idx].active = 1'b0;
          if (pc_over) begin
            n.desc[q.idx].outcome_code = htd_pkg::CC_OVERRUN;
            ev[htd_pkg::ST_ERR] = 1'b1;
          end else if (pc_under) begin
            n.desc[q.idx].outcome_code = htd_pkg::CC_UNDERRUN;
            ev[htd_pkg::ST_ERR] = 1'b1;
          end else if (!res.ok) begin
            n.desc[q.idx].outcome_code = res.outcome_code;
            ev[htd_pkg::ST_ERR] = 1'b1;
          end else begin
            n.desc[q.idx].toggle = ~cur.toggle;
            {n.desc[q.idx].moved_hi, n.desc[q.idx].moved_lo} = moved_new;
            if (cur.paired) begin
              n.ping_sent = !cur.pingpong;
            end
            // A short IN packet also ends the transfer
            if (moved_new >= f_total(cur) ||
                (cur.token_kind == htd_pkg::TK_IN && pc_count < q.tok.byte_len)) begin
              n.desc[q.idx].outcome_code = htd_pkg::CC_OK;
              ev[htd_pkg::ST_DESC_DONE]  = 1'b1;
            end else begin
              n.desc[q.idx].active = 1'b1;
            end
          end
        end
      end
      S_NEXT: begin
        if (list_end) begin
          n.fsm = S_IDLE;
          ev[htd_pkg::ST_LIST_DONE] = 1'b1;
        end else begin
          n.idx = IDX_W'(q.idx + 1'b1);
          n.fsm = S_SCAN;
        end
      end
      default: n.fsm = S_IDLE;
    endcase
    // Software writes land after engine write-back, so software wins a collision
    if (access && pwrite) begin
      case (paddr)
        htd_pkg::OFF_CTRL: begin
          n.ctrl_en = pwdata[htd_pkg::CTRL_EN_BIT];
          n.kind    = pwdata[htd_pkg::CTRL_KIND_LSB +: 2];
        end
        htd_pkg::OFF_MASK: n.mask = pwdata[htd_pkg::ST_W-1:0];
        htd_pkg::OFF_PEND: n.pend = pwdata[IDX_W-1:0];
        htd_pkg::OFF_AEND: n.aend = pwdata[IDX_W-1:0];
        default: begin
          if (f_desc_hit(paddr)) begin
            if (paddr[htd_pkg::WORD_SEL_BIT]) begin
              n.desc[di][63:32] = pwdata;
            end else begin
              n.desc[di][31:0] = pwdata;
            end
          end
        end
      endcase
    end
    // Clear only what the read returned; a new event in the same edge survives
    if (access && !pwrite && paddr == htd_pkg::OFF_STATUS) begin
      n.status = q.status & ~q.rdata[htd_pkg::ST_W-1:0];
    end
    n.status = n.status | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  htd_byte_pacer #(
    .CNT_W (htd_pkg::LEN_W)
  ) u_pacer (
    .pclk         (pclk),
    .presetn      (presetn),
    .clear        (start_pkt),
    .dir_in       (cur.token_kind == htd_pkg::TK_IN),
    .in_byte_stb  (in_byte_stb),
    .mem_wr_rdy   (mem_wr_rdy),
    .out_byte_req (out_byte_req),
    .mem_rd_rdy   (mem_rd_rdy),
    .byte_count   (pc_count),
    .overrun      (pc_over),
    .underrun     (pc_under)
  );

  assign prdata    = q.rdata;
  assign pready    = 1'b1;
  assign pslverr   = access && q.slverr;
  assign irq       = |(q.status & q.mask);
  assign tok_valid = q.fsm == S_WAIT;
  assign tok       = q.tok;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cur_toggle;
  assign cur_toggle = cur.toggle;

  AST_OVERRUN: assert property (
    tok_valid && res_valid && pc_over |=>
      cur.outcome_code == htd_pkg::CC_OVERRUN && !cur.active)
    else $error("overrun not recorded");
  AST_UNDERRUN: assert property (
    tok_valid && res_valid && !pc_over && pc_under |=>
      cur.outcome_code == htd_pkg::CC_UNDERRUN && !cur.active)
    else $error("underrun not recorded");
  AST_SKIP_IDLE: assert property (
    q.fsm == S_SCAN && !cur.active |=> q.fsm == S_NEXT && !tok_valid)
    else $error("inactive descriptor was issued");
  AST_TOGGLE_FLIP: assert property (
    tok_valid && res_valid && res.ok && !pc_over && !pc_under |=>
      cur_toggle != $past(cur_toggle))
    else $error("toggle not updated after good packet");
  AST_PKT_LIMIT: assert property (
    tok_valid |-> tok.byte_len <= f_mps(cur) && tok.byte_len <= f_total(cur))
    else $error("packet exceeds size limit");
  AST_TOKEN_FIELDS: assert property (
    $rose(tok_valid) |-> tok.endpoint_index == cur.endpoint_index &&
      tok.peripheral_addr == cur.peripheral_addr && tok.low_speed == cur.low_speed)
    else $error("token fields differ from descriptor");
  AST_NO_RSV_TOKEN: assert property (
    tok_valid |-> tok.token_kind != htd_pkg::TK_RSV)
    else $error("reserved token kind issued");
  AST_ISO_FRAME: assert property (
    q.kind == htd_pkg::LK_ISO && $rose(tok_valid) |->
      $past(q.frame[7:0]) == cur.sched_byte)
    else $error("isochronous descriptor sent in wrong frame");
  AST_DONE_CODE: assert property (
    ev[htd_pkg::ST_DESC_DONE] |=> cur.outcome_code == htd_pkg::CC_OK &&
      !cur.active ##1 q.status[htd_pkg::ST_DESC_DONE] || q.fsm != S_NEXT)
    else $error("completion without no-error code");
  AST_PONG_ORDER: assert property (
    $rose(tok_valid) && cur.paired && cur.pingpong |-> $past(q.ping_sent))
    else $error("pong half sent before ping half");

endmodule

// File: test/htd_usb_peer.sv
// USB peripheral model answering each token with byte strobes and a handshake
`timescale 1ns/100ps
module htd_usb_peer (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 tok_valid,
  input  wire htd_pkg::htd_token_s  tok,
  input  wire logic [3:0]           delay,
  input  wire logic [3:0]           link_err,
  output logic                      res_valid,
  output htd_pkg::htd_result_s      res,
  output logic                      in_byte_stb,
  output logic                      out_byte_req
);
  logic       busy;
  logic [3:0] wait_q;
  logic [9:0] left_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy         <= 1'b0;
      wait_q       <= 4'h0;
      left_q       <= 10'h0;
      res_valid    <= 1'b0;
      res          <= '0;
      in_byte_stb  <= 1'b0;
      out_byte_req <= 1'b0;
    end else begin
      res_valid    <= 1'b0;
      in_byte_stb  <= 1'b0;
      out_byte_req <= 1'b0;
      // Result lines mean nothing outside the pulse, so they never sit still
      res          <= ~res;
      if (tok_valid && !busy && !res_valid) begin
        busy   <= 1'b1;
        wait_q <= delay;
        left_q <= tok.byte_len;
      end else if (busy && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy && left_q != 10'h0) begin
        left_q       <= left_q - 10'h1;
        in_byte_stb  <= (tok.token_kind == htd_pkg::TK_IN);
        out_byte_req <= (tok.token_kind != htd_pkg::TK_IN);
      end else if (busy) begin
        busy      <= 1'b0;
        res_valid <= 1'b1;
        // A nonzero link error turns the handshake into a failed transaction
        res       <= '{ok: link_err == 4'h0, outcome_code: link_err};
      end
    end
  end
endmodule

// File: test/testbench.sv
// Self-checking bench of the transfer descriptor engine
`timescale 1ns/100ps
module testbench;
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, sof = 1'b0, mem_wr_rdy = 1'b1, mem_rd_rdy = 1'b1;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata;
  logic                 pready, pslverr, irq, tok_valid, res_valid, in_byte_stb, out_byte_req;
  logic                 tv_q = 1'b0;
  logic [3:0]           delay = 4'h0, link_err = 4'h0;
  htd_pkg::htd_token_s  tok;
  htd_pkg::htd_result_s res;
  htd_pkg::htd_token_s  tokq[$];
  int                   fail_count = 0, check_count = 0;

  always #2.5 pclk = ~pclk;

  htd_engine u_htd_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sof(sof), .tok_valid(tok_valid), .tok(tok),
    .res_valid(res_valid), .res(res), .in_byte_stb(in_byte_stb), .mem_wr_rdy(mem_wr_rdy),
    .out_byte_req(out_byte_req), .mem_rd_rdy(mem_rd_rdy));
  htd_usb_peer u_htd_usb_peer (.pclk(pclk), .presetn(presetn), .tok_valid(tok_valid),
    .tok(tok), .delay(delay), .link_err(link_err), .res_valid(res_valid), .res(res),
    .in_byte_stb(in_byte_stb), .out_byte_req(out_byte_req));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the edge that sees pready high; only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdw(input logic [7:0] a, output logic [31:0] rd);
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    rdw(a, rd);
    check(what, rd, exp);
  endtask

  function automatic htd_pkg::htd_desc_s mk(input logic [1:0] kind, input logic [9:0] mps,
      input logic [9:0] len, input logic [7:0] sched, input logic [2:0] flg);
    htd_pkg::htd_desc_s d;
    d = '0;
    d.token_kind = kind;
    d.peripheral_addr = 7'($urandom);
    d.endpoint_index = 4'($urandom);
    d.low_speed = 1'($urandom);
    {d.mps_hi, d.mps_lo} = mps;
    {d.len_hi, d.len_lo} = len;
    d.sched_byte = sched;
    {d.paired, d.pingpong, d.last} = flg;
    d.active = 1'b1;
    return d;
  endfunction

  function automatic htd_pkg::htd_token_s tk(input htd_pkg::htd_desc_s d, input logic t,
      input logic [9:0] n);
    return '{d.token_kind, d.peripheral_addr, d.endpoint_index, d.low_speed, t, n};
  endfunction

  function automatic logic [31:0] fin(input htd_pkg::htd_desc_s d, input logic t,
      input logic [9:0] n);
    d.active = 1'b0;
    d.toggle = t;
    d.outcome_code = htd_pkg::CC_OK;
    {d.moved_hi, d.moved_lo} = n;
    return d[31:0];
  endfunction

  task automatic wdesc(input int i, input htd_pkg::htd_desc_s d);
    wr(8'(htd_pkg::OFF_DESC + 8 * i), d[31:0]);
    wr(8'(htd_pkg::OFF_DESC + 8 * i + 4), d[63:32]);
  endtask

  // One frame start, then poll the busy flag until the scan has finished
  task automatic frame(input logic wrdy = 1'b1, input logic rrdy = 1'b1);
    logic [31:0] rd;
    int n;
    n = 0;
    @(posedge pclk);
    sof <= 1'b1;
    mem_wr_rdy <= wrdy;
    mem_rd_rdy <= rrdy;
    delay <= 4'($urandom);
    @(posedge pclk);
    sof <= 1'b0;
    repeat (3) @(posedge pclk);
    do begin
      rdw(htd_pkg::OFF_ENGINE, rd);
      n++;
    end while (rd[htd_pkg::ENG_BUSY_BIT] && n < 200);
    check("scan finished", rd[htd_pkg::ENG_BUSY_BIT], 1'b0);
    check("missing tokens", tokq.size(), 0);
  endtask

  // Every issued token must be the oldest one expected
  always @(negedge pclk) begin
    tv_q <= tok_valid;
    if (tok_valid === 1'b1 && tv_q !== 1'b1) begin
      if (tokq.size() == 0) check("unexpected token", 1'b1, 1'b0);
      else check("token", tok, tokq.pop_front());
    end
  end

  initial begin
    repeat (50000) @(posedge pclk);
    check("run finished", 1'b0, 1'b1);
    stop_test();
  end

  initial begin
    logic [31:0]        rd;
    logic               e, t;
    logic [9:0]         len;
    htd_pkg::htd_desc_s d, p;
    rd = $urandom(91);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk("reg reset", 8'(4 * i), 32'h0);
    apb(1'b0, 8'h42, 32'h0, rd, e);
    check("refused", {e, rd}, {1'b1, 32'h0});
    wr(htd_pkg::OFF_FRAME, 32'h5);
    rd_chk("frame ro", htd_pkg::OFF_FRAME, 32'h0);
    $display("TEST registers done");
    wr(htd_pkg::OFF_MASK, 32'h1 << htd_pkg::ST_DESC_DONE);
    wr(htd_pkg::OFF_CTRL, 32'h1);
    d = mk(htd_pkg::TK_OUT, 10'h8, 10'h14, 8'h00, 3'b000);
    wdesc(0, d);
    for (int i = 0; i < 3; i++) begin
      tokq.push_back(tk(d, 1'(i), (i == 2) ? 10'h4 : 10'h8));
      frame();
    end
    frame();
    rd_chk("multi packet", htd_pkg::OFF_DESC, fin(d, 1'b1, 10'h14));
    check("irq raised", irq, 1'b1);
    rd_chk("status", htd_pkg::OFF_STATUS, 32'h5);
    @(negedge pclk);
    check("irq cleared", irq, 1'b0);
    $display("TEST multi packet done");
    // Third pass: memory keeps up but the link reports its own error code
    for (int k = 0; k < 3; k++) begin
      d = mk((k == 1) ? htd_pkg::TK_OUT : htd_pkg::TK_IN, 10'h8, 10'h8, 8'h00, 3'b000);
      wdesc(0, d);
      tokq.push_back(tk(d, 1'b0, 10'h8));
      link_err <= (k == 2) ? 4'h5 : 4'h0;
      frame(1'(k != 0), 1'(k != 1));
      rdw(htd_pkg::OFF_DESC, rd);
      check("fault code", rd[15:10], {(k == 2) ? 4'h5 :
        (k ? htd_pkg::CC_UNDERRUN : htd_pkg::CC_OVERRUN), 2'b00});
    end
    link_err <= 4'h0;
    check("irq masked", irq, 1'b0);
    rd_chk("status err", htd_pkg::OFF_STATUS, 32'h6);
    $display("TEST memory faults done");
    for (int k = 0; k < 4; k++) begin
      len = 10'($urandom_range(1, 16));
      d = mk(2'(k), 10'h10, len, 8'h00, 3'b000);
      wdesc(0, d);
      if (k < 3) tokq.push_back(tk(d, 1'b0, len));
      frame();
      rd_chk("token kind", htd_pkg::OFF_DESC, (k == 3) ? d[31:0] : fin(d, 1'b1, len));
    end
    $display("TEST token kinds done");
    p = mk(htd_pkg::TK_OUT, 10'h8, 10'h8, 8'h00, 3'b111);
    d = p;
    d.pingpong = 1'b0;
    d.last = 1'b0;
    wdesc(0, p);
    wdesc(1, d);
    wr(htd_pkg::OFF_AEND, 32'h1);
    tokq.push_back(tk(d, 1'b0, 10'h8));
    frame();
    tokq.push_back(tk(p, 1'b0, 10'h8));
    frame();
    $display("TEST paired done");
    wdesc(0, '0);
    wr(htd_pkg::OFF_CTRL, 32'h1 | (32'(htd_pkg::LK_ISO) << htd_pkg::CTRL_KIND_LSB));
    rdw(htd_pkg::OFF_FRAME, rd);
    d = mk(htd_pkg::TK_IN, 10'h8, 10'h8, 8'(rd + 2), 3'b001);
    p = mk(htd_pkg::TK_IN, 10'h8, 10'h8, 8'(rd + 2), 3'b000);
    wdesc(1, d);
    wdesc(2, p);
    frame();
    tokq.push_back(tk(d, 1'b0, 10'h8));
    frame();
    rd_chk("after last", 8'(htd_pkg::OFF_DESC + 16), p[31:0]);
    $display("TEST isochronous done");
    wr(htd_pkg::OFF_CTRL, 32'h1 | (32'(htd_pkg::LK_INTR) << htd_pkg::CTRL_KIND_LSB));
    for (int x = 1; x < 3; x++) begin
      rdw(htd_pkg::OFF_FRAME, rd);
      d = mk(htd_pkg::TK_IN, 10'h4, 10'h3c, {3'(x), 5'($urandom)}, 3'b000);
      wdesc(0, d);
      t = 1'b0;
      for (int i = 1; i < 9; i++) begin
        if (((8'(rd + i) ^ {3'b000, d.sched_byte[4:0]}) & 8'((1 << x) - 1)) == 8'h00) begin
          tokq.push_back(tk(d, t, 10'h4));
          t = ~t;
        end
        frame();
      end
    end
    $display("TEST interrupt polling done");
    stop_test();
  end
endmodule
